//--- pcc_pkg.sv
// Behaviour
// (R1) Fixed read-only maker code at offset 0
// (R2) Fixed read-only part code at offset 2
// (R3) Command register at offset 4, resets zero
// (R4) Each function owns a separate command register
// (R5) Fault and parity enables ORed across functions
// (R6) Command bits 15 to 11 read zero
// (R7) Bit 10 set blocks interrupt assertion
// (R8) Bit 9 back-to-back read-only zero
// (R9) Bit 8 enables system fault driver
// (R10) Address parity reported only with bits 8,6
// (R11) Command bit 7 reads zero
// (R12) Bit 6 gates parity error signalling
// (R13) Bit 5 snoops palette writes unclaimed
// (R14) Bit 4 hardwired zero, plain writes only
// (R15) Bit 3 hardwired zero, no special cycles
// (R16) Bit 2 gates initiator bus requests
// (R17) Bit 1 gates memory space claims
// (R18) Bit 0 gates I/O space claims
// (R19) Writes to read-only bits change nothing
package pcc_pkg;
    localparam logic [7:0] OFS_MAKER = 8'h00;
    localparam logic [7:0] OFS_PART = 8'h02;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    // Writable bits: 10, 8, 6, 5, 2, 1, 0
    localparam logic [15:0] CMD_WMASK = 16'h0567;
    localparam int BIT_INT_OFF = 10;
    localparam int BIT_FBB = 9;
    localparam int BIT_SERR = 8;
    localparam int BIT_PERR = 6;
    localparam int BIT_VGA = 5;
    localparam int BIT_MWI = 4;
    localparam int BIT_SPC = 3;
    localparam int BIT_MAST = 2;
    localparam int BIT_MEM = 1;
    localparam int BIT_IO = 0;
    localparam int NFUNC = 2;
endpackage

//--- pcc_cmd_regs.sv
`timescale 1ns/1ps
// Configuration read data is registered: it appears the cycle after cfg_rd.
module pcc_cmd_regs
#(
    // Arbitrary neutral identification values
    parameter logic [15:0] MAKER_ID = 16'h1234,
    parameter logic [15:0] PART_ID = 16'h5678
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [pcc_pkg::NFUNC-1:0] cfg_func,
    input wire logic [7:0] cfg_addr,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    input wire logic [pcc_pkg::NFUNC-1:0] int_req,
    input wire logic [pcc_pkg::NFUNC-1:0] mast_req,
    input wire logic [pcc_pkg::NFUNC-1:0] mem_hit,
    input wire logic [pcc_pkg::NFUNC-1:0] io_hit,
    input wire logic [pcc_pkg::NFUNC-1:0] palette_wr,
    input wire logic addr_par_err,
    input wire logic data_par_err,
    output logic [pcc_pkg::NFUNC-1:0] int_assert,
    output logic [pcc_pkg::NFUNC-1:0] mast_grant_req,
    output logic [pcc_pkg::NFUNC-1:0] mem_claim,
    output logic [pcc_pkg::NFUNC-1:0] io_claim,
    output logic [pcc_pkg::NFUNC-1:0] palette_claim,
    output logic [pcc_pkg::NFUNC-1:0] palette_snoop,
    output logic system_fault_drive_allow,
    output logic parity_response_allow,
    output logic serr_assert,
    output logic perr_assert
);
    import pcc_pkg::*;

    logic [15:0] cmd [NFUNC];
    logic [15:0] next_cmd [NFUNC];
    logic [15:0] next_rdata;
    logic [NFUNC-1:0] next_int;
    logic [NFUNC-1:0] next_mast;
    logic [NFUNC-1:0] next_mem;
    logic [NFUNC-1:0] next_io;
    logic [NFUNC-1:0] next_pclaim;
    logic [NFUNC-1:0] next_psnoop;
    logic next_system_fault_drive_allow;
    logic next_parity_response_allow;
    logic next_serr;
    logic next_perr;

    genvar f;
    generate
        for (f = 0; f < NFUNC; f++)
        begin : g_func
            // Separate register per function, only writable bits stored
            always_comb
            begin
                next_cmd[f] = cmd[f];
                if (cfg_wr && cfg_func[f] && cfg_addr == OFS_CMD) // R4
                    next_cmd[f] = cfg_wdata & CMD_WMASK; // R6 R8 R11 R14 R15 R19
                next_int[f] = int_req[f] && !cmd[f][BIT_INT_OFF]; // R7
                next_mast[f] = mast_req[f] && cmd[f][BIT_MAST]; // R16
                next_mem[f] = mem_hit[f] && cmd[f][BIT_MEM]; // R17
                next_io[f] = io_hit[f] && cmd[f][BIT_IO]; // R18
                next_pclaim[f] = palette_wr[f] && !cmd[f][BIT_VGA]; // R13
                next_psnoop[f] = palette_wr[f] && cmd[f][BIT_VGA]; // R13
            end
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    cmd[f] <= CMD_RESET; // R3
                else
                    cmd[f] <= next_cmd[f];
            end
        end
    endgenerate

    always_comb
    begin
        // Wired OR of the two functions' enables
        next_system_fault_drive_allow = cmd[0][BIT_SERR] || cmd[1][BIT_SERR]; // R5
        next_parity_response_allow = cmd[0][BIT_PERR] || cmd[1][BIT_PERR]; // R5
        next_serr = addr_par_err && next_system_fault_drive_allow && next_parity_response_allow; // R9 R10 R12
        next_perr = data_par_err && next_parity_response_allow; // R12
        next_rdata = 16'h0000;
        if (cfg_rd)
        begin
            case (cfg_addr)
                OFS_MAKER: next_rdata = MAKER_ID; // R1
                OFS_PART: next_rdata = PART_ID; // R2
                OFS_CMD: next_rdata = cfg_func[1] ? cmd[1] : cmd[0]; // R4
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_rdata <= 16'h0000;
            int_assert <= '0;
            mast_grant_req <= '0;
            mem_claim <= '0;
            io_claim <= '0;
            palette_claim <= '0;
            palette_snoop <= '0;
            system_fault_drive_allow <= 1'b0;
            parity_response_allow <= 1'b0;
            serr_assert <= 1'b0;
            perr_assert <= 1'b0;
        end
        else
        begin
            cfg_rdata <= next_rdata;
            int_assert <= next_int;
            mast_grant_req <= next_mast;
            mem_claim <= next_mem;
            io_claim <= next_io;
            palette_claim <= next_pclaim;
            palette_snoop <= next_psnoop;
            system_fault_drive_allow <= next_system_fault_drive_allow;
            parity_response_allow <= next_parity_response_allow;
            serr_assert <= next_serr;
            perr_assert <= next_perr;
        end
    end

    a_cmd_readback: assert property ( // R6
        @(posedge mclk) disable iff (!rst_n)
        cfg_rd && cfg_addr == OFS_CMD |=> (cfg_rdata & ~CMD_WMASK) == 16'h0000)
        else $error("reserved command bits read nonzero");

    a_maker_code: assert property ( // R1
        @(posedge mclk) disable iff (!rst_n)
        cfg_rd && cfg_addr == OFS_MAKER |=> cfg_rdata == MAKER_ID)
        else $error("maker code wrong");

    a_part_code: assert property ( // R2
        @(posedge mclk) disable iff (!rst_n)
        cfg_rd && cfg_addr == OFS_PART |=> cfg_rdata == PART_ID)
        else $error("part code wrong");

    a_rdata_idle: assert property ( // R6
        @(posedge mclk) disable iff (!rst_n)
        !cfg_rd |=> cfg_rdata == 16'h0000)
        else $error("read data without a read");

    a_read_func1: assert property ( // R4
        @(posedge mclk) disable iff (!rst_n)
        cfg_rd && cfg_addr == OFS_CMD && cfg_func[1] |=> cfg_rdata == $past(cmd[1]))
        else $error("function one readback wrong");

    a_read_func0: assert property ( // R4
        @(posedge mclk) disable iff (!rst_n)
        cfg_rd && cfg_addr == OFS_CMD && !cfg_func[1] |=> cfg_rdata == $past(cmd[0]))
        else $error("function zero readback wrong");

    a_write_iso: assert property ( // R4
        @(posedge mclk) disable iff (!rst_n)
        cfg_wr && cfg_func == 2'b01 && cfg_addr == OFS_CMD |=> cmd[1] == $past(cmd[1]))
        else $error("write leaked to function one");

    a_write_iso_b: assert property ( // R4
        @(posedge mclk) disable iff (!rst_n)
        cfg_wr && cfg_func == 2'b10 && cfg_addr == OFS_CMD |=> cmd[0] == $past(cmd[0]))
        else $error("write leaked to function zero");

    a_fault_or: assert property ( // R5
        @(posedge mclk) disable iff (!rst_n)
        system_fault_drive_allow == $past(cmd[0][BIT_SERR] || cmd[1][BIT_SERR]))
        else $error("fault enable not ORed");

    a_parity_or: assert property ( // R5
        @(posedge mclk) disable iff (!rst_n)
        parity_response_allow == $past(cmd[0][BIT_PERR] || cmd[1][BIT_PERR]))
        else $error("parity enable not ORed");

    a_serr_gate: assert property ( // R10
        @(posedge mclk) disable iff (!rst_n)
        serr_assert |-> $past(addr_par_err) && $past(next_system_fault_drive_allow) && $past(next_parity_response_allow))
        else $error("system fault without cause");

    a_serr_fire: assert property ( // R9
        @(posedge mclk) disable iff (!rst_n)
        addr_par_err && next_system_fault_drive_allow && next_parity_response_allow |=> serr_assert)
        else $error("address parity not reported");

    a_fault_idle: assert property ( // R9
        @(posedge mclk) disable iff (!rst_n)
        !system_fault_drive_allow |-> !serr_assert)
        else $error("system fault while driver off");

    a_serr_perr: assert property ( // R10
        @(posedge mclk) disable iff (!rst_n)
        serr_assert |-> parity_response_allow)
        else $error("system fault without parity enable");

    a_perr_gate: assert property ( // R12
        @(posedge mclk) disable iff (!rst_n)
        data_par_err && next_parity_response_allow |=> perr_assert)
        else $error("parity error not signalled");

    a_perr_quiet: assert property ( // R12
        @(posedge mclk) disable iff (!rst_n)
        perr_assert |-> $past(data_par_err) && $past(next_parity_response_allow))
        else $error("parity error without cause");

    a_parity_idle: assert property ( // R12
        @(posedge mclk) disable iff (!rst_n)
        !parity_response_allow |-> !perr_assert)
        else $error("parity error while response off");

    // Per-function checks, one copy for each command register
    generate
        for (f = 0; f < NFUNC; f++)
        begin : g_chk
            a_reset_zero: assert property ( // R3
                @(posedge mclk) disable iff (!rst_n)
                $past(!rst_n) |-> cmd[f] == CMD_RESET)
                else $error("command not zero after reset");

            a_store_mask: assert property ( // R19
                @(posedge mclk) disable iff (!rst_n)
                (cmd[f] & ~CMD_WMASK) == 16'h0000)
                else $error("read-only command bit stored");

            a_hold_cmd: assert property ( // R19
                @(posedge mclk) disable iff (!rst_n)
                !(cfg_wr && cfg_func[f] && cfg_addr == OFS_CMD) |=> cmd[f] == $past(cmd[f]))
                else $error("command changed without write");

            a_write_take: assert property ( // R4
                @(posedge mclk) disable iff (!rst_n)
                cfg_wr && cfg_func[f] && cfg_addr == OFS_CMD
                |=> cmd[f] == ($past(cfg_wdata) & CMD_WMASK))
                else $error("command write lost");

            a_fbb_zero: assert property ( // R8
                @(posedge mclk) disable iff (!rst_n)
                !cmd[f][BIT_FBB])
                else $error("back-to-back bit set");

            a_wrinv_zero: assert property ( // R14
                @(posedge mclk) disable iff (!rst_n)
                !cmd[f][BIT_MWI])
                else $error("write-invalidate bit set");

            a_special_zero: assert property ( // R15
                @(posedge mclk) disable iff (!rst_n)
                !cmd[f][BIT_SPC])
                else $error("special cycle bit set");

            a_int_block: assert property ( // R7
                @(posedge mclk) disable iff (!rst_n)
                int_req[f] && cmd[f][BIT_INT_OFF] |=> !int_assert[f])
                else $error("interrupt asserted while disabled");

            a_int_pass: assert property ( // R7
                @(posedge mclk) disable iff (!rst_n)
                int_req[f] && !cmd[f][BIT_INT_OFF] |=> int_assert[f])
                else $error("interrupt lost while enabled");

            a_mast_gate: assert property ( // R16
                @(posedge mclk) disable iff (!rst_n)
                mast_grant_req[f] |-> $past(cmd[f][BIT_MAST]))
                else $error("request while mastering off");

            a_mast_pass: assert property ( // R16
                @(posedge mclk) disable iff (!rst_n)
                mast_req[f] && cmd[f][BIT_MAST] |=> mast_grant_req[f])
                else $error("bus request lost");

            a_mem_gate: assert property ( // R17
                @(posedge mclk) disable iff (!rst_n)
                mem_hit[f] && cmd[f][BIT_MEM] |=> mem_claim[f])
                else $error("memory claim missed");

            a_mem_block: assert property ( // R17
                @(posedge mclk) disable iff (!rst_n)
                mem_claim[f] |-> $past(cmd[f][BIT_MEM]))
                else $error("memory claim while disabled");

            a_io_gate: assert property ( // R18
                @(posedge mclk) disable iff (!rst_n)
                io_claim[f] |-> $past(cmd[f][BIT_IO]))
                else $error("I/O claim while disabled");

            a_io_pass: assert property ( // R18
                @(posedge mclk) disable iff (!rst_n)
                io_hit[f] && cmd[f][BIT_IO] |=> io_claim[f])
                else $error("I/O claim missed");

            a_snoop_gate: assert property ( // R13
                @(posedge mclk) disable iff (!rst_n)
                !(palette_claim[f] && palette_snoop[f]))
                else $error("palette claimed and snooped");

            a_snoop_take: assert property ( // R13
                @(posedge mclk) disable iff (!rst_n)
                palette_wr[f] && cmd[f][BIT_VGA] |=> palette_snoop[f] && !palette_claim[f])
                else $error("palette write not snooped");

            a_palette_claim: assert property ( // R13
                @(posedge mclk) disable iff (!rst_n)
                palette_wr[f] && !cmd[f][BIT_VGA] |=> palette_claim[f] && !palette_snoop[f])
                else $error("palette write not claimed");
        end
    endgenerate
endmodule

//--- pcc_host.sv
`timescale 1ns/1ps
module pcc_host
(
    input wire logic mclk,
    input wire logic [15:0] cfg_rdata,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [1:0] cfg_func,
    output logic [7:0] cfg_addr,
    output logic [15:0] cfg_wdata
);
    initial {cfg_wr, cfg_rd, cfg_func, cfg_addr, cfg_wdata} = '0;
    // Released data lines are inverted, never left stale
    task automatic xfer(input logic w, input logic [1:0] f, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] q);
        @(posedge mclk);
        {cfg_wr, cfg_rd, cfg_func, cfg_addr, cfg_wdata} <= {w, !w, f, a, d};
        @(posedge mclk);
        {cfg_wr, cfg_rd, cfg_wdata} <= {2'b00, ~d};
        #1 q = cfg_rdata;
    endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [15:0] MK = 16'ha5c3, PT = 16'h3c5a; // Arbitrary codes
    logic mclk = 1'b0, rst_n = 1'b0;
    logic cfg_wr, cfg_rd;
    logic [1:0] cfg_func;
    logic [7:0] cfg_addr;
    logic [15:0] cfg_wdata, cfg_rdata, q;
    wire logic [15:0] outs;
    logic [11:0] lvl = '0;
    int cmd[2], error_cnt, check_count;
    initial forever #2.5 mclk = ~mclk;
    pcc_host host (.mclk, .cfg_rdata, .cfg_wr, .cfg_rd, .cfg_func, .cfg_addr, .cfg_wdata);
    pcc_cmd_regs #(.MAKER_ID(MK), .PART_ID(PT)) dut (.mclk, .rst_n, .cfg_wr, .cfg_rd,
        .cfg_func, .cfg_addr, .cfg_wdata, .cfg_rdata, .addr_par_err(lvl[11]),
        .data_par_err(lvl[10]), .int_req(lvl[9:8]), .mast_req(lvl[7:6]), .mem_hit(lvl[5:4]),
        .io_hit(lvl[3:2]), .palette_wr(lvl[1:0]), .int_assert(outs[15:14]),
        .mast_grant_req(outs[13:12]), .mem_claim(outs[11:10]), .io_claim(outs[9:8]),
        .palette_claim(outs[7:6]), .palette_snoop(outs[5:4]), .system_fault_drive_allow(outs[3]),
        .parity_response_allow(outs[2]), .serr_assert(outs[1]), .perr_assert(outs[0]));
    function automatic logic [1:0] bits(input int n);
        return {cmd[1][n], cmd[0][n]};
    endfunction
    function automatic logic [15:0] exp_out();
        return {lvl[9:8] & ~bits(10), lvl[7:6] & bits(2), lvl[5:4] & bits(1),
            lvl[3:2] & bits(0), lvl[1:0] & ~bits(5), lvl[1:0] & bits(5), |bits(8), |bits(6),
            lvl[11] & (|bits(8)) & (|bits(6)), lvl[10] & (|bits(6))};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        error_cnt += int'(g !== e);
        if (g !== e)
            $display("BAD %s exp %h got %h", n, e, g);
    endtask
    task automatic op(input logic w, input logic [1:0] f, input logic [7:0] a,
        input logic [15:0] d);
        host.xfer(w, f, a, d, q);
        chk("rdata", w ? 16'h0000 : a == 8'h00 ? MK : a == 8'h02 ? PT :
            a == 8'h04 ? 16'(cmd[f[1]]) : 16'h0000, q);
        for (int i = 0; i < 2; i++)
            cmd[i] = (w && f[i] && a == 8'h04) ? int'(d & 16'h0567) : cmd[i];
    endtask
    task automatic end_of_test(input int extra);
        error_cnt += extra;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial #20000 end_of_test(1);
    initial
    begin
        void'($urandom(29));
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a += 2)
        begin
            op(1'b0, 2'(a + 2), 8'(a), 16'h0000);
            op(1'b1, 2'(a + 1), 8'(a), 16'hffff);
            op(1'b0, 2'b00, 8'(a), 16'h0000);
        end
        $display("test register map done");
        repeat (60)
        begin
            op(1'b1, 2'($urandom), 8'h04, 16'($urandom));
            @(posedge mclk);
            lvl <= 12'($urandom);
            op(1'b0, 2'($urandom), 8'h04, 16'h0000);
            chk("outputs", exp_out(), outs);
        end
        $display("test command effects done");
        end_of_test(0);
    end
endmodule
